// ### hw/bit_synchronizer.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
`default_nettype none
module bit_synchronizer #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_enable_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] synced_out
);
    logic [WIDTH-1:0] first_stage;

    initial begin
        if (WIDTH < 1) begin
            $error("bit_synchronizer: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            first_stage <= '0;
            synced_out <= '0;
        end else if (clk_enable_in) begin
            first_stage <= async_in;
            synced_out <= first_stage;
        end
    end
endmodule
`default_nettype wire

// ### hw/reset_source_mux.sv
// Per-timer decode of the reset source field into one external reset level
`timescale 1ns/100ps
`default_nettype none
`include "timer_reset_select_params.svh"
module reset_source_mux #(
    parameter int OWN_INDEX = 0
) (
    // Selection
    input wire timer_reset_select_pkg::reset_source_field_type reset_source_field_in,
    // Sources: pin, comparators, ccp, timers, zero cross, logic cells, pwm
    input wire logic pin_in,
    input wire logic comparator_one_synced_in,
    input wire logic comparator_two_synced_in,
    input wire logic capture_compare_one_output_in,
    input wire logic capture_compare_two_output_in,
    input wire logic [2:0] timer_postscaled_in,
    input wire logic zero_cross_output_in,
    input wire logic [3:0] logic_cell_output_in,
    input wire logic pwm_three_output_in,
    input wire logic pwm_four_output_in,
    // Result
    output logic ext_reset_out,
    output logic reserved_out
);
    import timer_reset_select_pkg::*;

    initial begin
        if (OWN_INDEX < 0 || OWN_INDEX > 2) begin
            $error("reset_source_mux: OWN_INDEX must be 0, 1 or 2");
        end
    end

    // Own postscaled output is never offered back to the same timer
    wire logic [2:0] timer_allowed = ~(3'h1 << OWN_INDEX);
    wire logic [1:0] timer_sel = 2'(reset_source_field_in - `CODE_FIRST_TIMER);
    wire logic is_timer_code = (reset_source_field_in >= `CODE_FIRST_TIMER) &&
                               (reset_source_field_in <= `CODE_THIRD_TIMER);
    wire logic self_code = is_timer_code && !timer_allowed[timer_sel];
    wire logic [1:0] cell_sel = 2'(reset_source_field_in - `CODE_LOGIC_ONE);

    always_comb begin
        ext_reset_out = 1'b0;
        case (reset_source_field_in)
            `CODE_PIN: ext_reset_out = pin_in;
            `CODE_COMP_ONE: ext_reset_out = comparator_one_synced_in;
            `CODE_COMP_TWO: ext_reset_out = comparator_two_synced_in;
            `CODE_CCP_ONE: ext_reset_out = capture_compare_one_output_in;
            `CODE_CCP_TWO: ext_reset_out = capture_compare_two_output_in;
            `CODE_FIRST_TIMER, `CODE_SECOND_TIMER, `CODE_THIRD_TIMER: begin
                ext_reset_out = timer_postscaled_in[timer_sel] & !self_code;
            end
            `CODE_ZERO_CROSS: ext_reset_out = zero_cross_output_in;
            `CODE_LOGIC_ONE, `CODE_LOGIC_TWO, `CODE_LOGIC_THREE, `CODE_LOGIC_FOUR: begin
                ext_reset_out = logic_cell_output_in[cell_sel];
            end
            `CODE_PWM_THREE: ext_reset_out = pwm_three_output_in;
            `CODE_PWM_FOUR: ext_reset_out = pwm_four_output_in;
            default: ext_reset_out = 1'b0;
        endcase
    end

    assign reserved_out = self_code || (reset_source_field_in == `CODE_RESERVED);
endmodule
`default_nettype wire

// ### hw/timer_ext_reset_source_select.sv
// External reset source selector for three auto-reload timers, with APB registers
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "timer_reset_select_params.svh"
module timer_ext_reset_source_select #(
    parameter int TIMER_COUNT = 3,
    parameter int PIN_COUNT = 8
) (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_enable_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Pin source: pins and the timer input pin-select setting
    input wire logic [PIN_COUNT-1:0] input_pins_in,
    input wire logic [$clog2(PIN_COUNT)-1:0] timer_input_pin_select_in,
    // On-chip sources, same clock
    input wire logic comparator_one_synced_in,
    input wire logic comparator_two_synced_in,
    input wire logic capture_compare_one_output_in,
    input wire logic capture_compare_two_output_in,
    input wire logic first_timer_postscaled_in,
    input wire logic second_timer_postscaled_in,
    input wire logic third_timer_postscaled_in,
    input wire logic zero_cross_output_in,
    input wire logic logic_cell_one_output_in,
    input wire logic logic_cell_two_output_in,
    input wire logic logic_cell_three_output_in,
    input wire logic logic_cell_four_output_in,
    input wire logic pwm_three_output_in,
    input wire logic pwm_four_output_in,
    // External resets, one per timer
    output logic [TIMER_COUNT-1:0] timer_ext_reset_out
);
    import timer_reset_select_pkg::*;

    initial begin
        if (TIMER_COUNT != 3) begin
            $error("timer_ext_reset_source_select: TIMER_COUNT must be 3");
        end
        if (PIN_COUNT < 2) begin
            $error("timer_ext_reset_source_select: PIN_COUNT must be at least 2");
        end
    end

    reset_source_field_type reset_source_field [TIMER_COUNT];
    logic [PIN_COUNT-1:0] pins_synced;
    logic [TIMER_COUNT-1:0] next_ext_reset;
    logic [TIMER_COUNT-1:0] reserved_now;
    logic [TIMER_COUNT-1:0] next_reserved;
    logic [TIMER_COUNT-1:0] reserved_seen;

    // Pins come from outside the clock domain
    bit_synchronizer #(
        .WIDTH(PIN_COUNT)
    ) pin_sync (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .clk_enable_in(clk_enable_in),
        .async_in(input_pins_in),
        .synced_out(pins_synced)
    );

    wire logic selected_pin = pins_synced[timer_input_pin_select_in];
    wire logic [2:0] postscaled = {third_timer_postscaled_in, second_timer_postscaled_in,
                                   first_timer_postscaled_in};
    wire logic [3:0] cells = {logic_cell_four_output_in, logic_cell_three_output_in,
                              logic_cell_two_output_in, logic_cell_one_output_in};

    genvar t;
    generate
        for (t = 0; t < TIMER_COUNT; t++) begin : g_timer
            reset_source_mux #(
                .OWN_INDEX(t)
            ) mux (
                .reset_source_field_in(reset_source_field[t]),
                .pin_in(selected_pin),
                .comparator_one_synced_in(comparator_one_synced_in),
                .comparator_two_synced_in(comparator_two_synced_in),
                .capture_compare_one_output_in(capture_compare_one_output_in),
                .capture_compare_two_output_in(capture_compare_two_output_in),
                .timer_postscaled_in(postscaled),
                .zero_cross_output_in(zero_cross_output_in),
                .logic_cell_output_in(cells),
                .pwm_three_output_in(pwm_three_output_in),
                .pwm_four_output_in(pwm_four_output_in),
                .ext_reset_out(next_ext_reset[t]),
                .reserved_out(reserved_now[t])
            );
        end
    endgenerate

    // APB decode: single-cycle access phase, zero wait states
    wire logic access = psel_in && penable_in;
    wire logic [1:0] word_index = paddr_in[3:2];
    wire logic addr_hit = (paddr_in[11:4] == 8'h00) && (paddr_in[1:0] == 2'h0);
    wire logic is_field_reg = addr_hit && (word_index != 2'h3);
    wire logic is_status_reg = addr_hit && (word_index == 2'h3);
    wire logic bad_access = !addr_hit || (is_status_reg && pwrite_in);
    // A setup cycle lost to a low enable is answered late, so no transfer can hang
    wire logic answer_now = psel_in && (!penable_in || !pready_out);
    wire logic field_write = access && pready_out && pwrite_in && is_field_reg && pstrb_in[0];
    wire reset_source_field_type write_field =
        pwdata_in[`RESET_SOURCE_FIELD_LSB +: `RESET_SOURCE_FIELD_WIDTH];
    // Status shows which timers currently hold a reserved code
    assign next_reserved = reserved_now;

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_field_reg) begin
            next_rdata[`RESET_SOURCE_FIELD_LSB +: `RESET_SOURCE_FIELD_WIDTH] =
                reset_source_field[word_index]; // upper bits stay zero
        end else if (is_status_reg) begin
            next_rdata[TIMER_COUNT-1:0] = reserved_seen;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < TIMER_COUNT; i++) begin
                reset_source_field[i] <= `RESET_SOURCE_FIELD_RESET;
            end
        end else if (clk_enable_in && field_write) begin
            reset_source_field[word_index] <= write_field;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (clk_enable_in) begin
            // Answer in the setup cycle so pready is high at the first access edge
            pready_out <= answer_now;
            pslverr_out <= answer_now && bad_access;
            prdata_out <= (answer_now && !pwrite_in) ? next_rdata : 32'h0000_0000;
        end
    end

    // Registered outputs cost one cycle of latency on the reset path
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            timer_ext_reset_out <= '0;
            reserved_seen <= '0;
        end else if (clk_enable_in) begin
            timer_ext_reset_out <= next_ext_reset;
            reserved_seen <= next_reserved;
        end
    end
endmodule
`default_nettype wire

// ### hw/timer_reset_select_params.svh
// Offsets, field layout, reset values and codes of the external reset selector
`ifndef TIMER_RESET_SELECT_PARAMS_SVH
`define TIMER_RESET_SELECT_PARAMS_SVH

// Register byte addresses on the APB slave
`define FIRST_TIMER_RESET_SOURCE_SELECT_ADDR 12'h000
`define SECOND_TIMER_RESET_SOURCE_SELECT_ADDR 12'h004
`define THIRD_TIMER_RESET_SOURCE_SELECT_ADDR 12'h008
`define SELECTOR_STATUS_ADDR 12'h00C

// Field layout
`define RESET_SOURCE_FIELD_LSB 0
`define RESET_SOURCE_FIELD_WIDTH 4
`define RESET_SOURCE_FIELD_RESET 4'h0

// Source codes
`define CODE_PIN 4'h0
`define CODE_COMP_ONE 4'h1
`define CODE_COMP_TWO 4'h2
`define CODE_CCP_ONE 4'h3
`define CODE_CCP_TWO 4'h4
`define CODE_FIRST_TIMER 4'h5
`define CODE_SECOND_TIMER 4'h6
`define CODE_THIRD_TIMER 4'h7
`define CODE_ZERO_CROSS 4'h8
`define CODE_LOGIC_ONE 4'h9
`define CODE_LOGIC_TWO 4'hA
`define CODE_LOGIC_THREE 4'hB
`define CODE_LOGIC_FOUR 4'hC
`define CODE_PWM_THREE 4'hD
`define CODE_PWM_FOUR 4'hE
`define CODE_RESERVED 4'hF

`endif

// ### hw/timer_reset_select_pkg.sv
// Types shared by the external reset selector
package timer_reset_select_pkg;
    typedef logic [3:0] reset_source_field_type;
    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_ACCESS = 2'b01
    } apb_phase_type;
endpackage

// ### tb/reset_source_model.sv
// Model of the on-chip peripherals and pins feeding the selector
`timescale 1ns/100ps
`default_nettype none
module reset_source_model (
    // Pattern control
    input wire logic [3:0] code_in,
    input wire logic [2:0] pin_sel_in,
    input wire logic hit_in,
    // Source levels, bit n belongs to code n+1
    output logic [13:0] source_out,
    output logic [7:0] pins_out
);
    // On a miss every other source is high, so any wrong route shows as a one
    assign source_out = hit_in ? 14'h0001 << (code_in - 4'h1) : ~(14'h0001 << (code_in - 4'h1));
    assign pins_out = hit_in ? 8'h01 << pin_sel_in : ~(8'h01 << pin_sel_in);
endmodule
`default_nettype wire

// ### tb/timer_ext_reset_source_select_sva.sv
// Port-level checks on the external reset selector
`timescale 1ns/100ps
`default_nettype none
module timer_ext_reset_source_select_sva #(
    parameter int TIMER_COUNT = 3,
    parameter int PIN_COUNT = 8
) (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_enable_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Sources and results
    input wire logic comparator_one_synced_in,
    input wire logic [TIMER_COUNT-1:0] timer_ext_reset_out
);
    logic [3:0] shadow [3];
    wire logic take;
    // Own copy of the fields, so routing can be judged without the body
    assign take = psel_in && penable_in && pready_out && clk_enable_in;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shadow <= '{default: 4'h0};
        end else if (take && pwrite_in && pstrb_in[0] && paddr_in < 12'h00C) begin
            shadow[paddr_in[3:2]] <= pwdata_in[3:0];
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    a_ready_pulse: assert property (pready_out && clk_enable_in |=> !pready_out)
        else $error("pready longer than one cycle");
    a_ready_follows: assert property (psel_in && !penable_in && clk_enable_in |=> pready_out)
        else $error("no answer in first access cycle");
    a_read_upper_zero: assert property (pready_out && !pwrite_in |-> prdata_out[31:4] == 28'h0)
        else $error("upper read bits not zero");
    a_unmapped_err: assert property (take && paddr_in > 12'h00C |-> pslverr_out)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (take && paddr_in < 12'h00C && paddr_in[1:0] == 2'h0
        |-> !pslverr_out)
        else $error("select register access refused");
    a_reset_clear: assert property ($rose(resetn_in) |-> timer_ext_reset_out == '0)
        else $error("external reset active after reset");
    a_reserved_quiet: assert property (shadow[0] == 4'hF && $past(shadow[0]) == 4'hF
        |-> !timer_ext_reset_out[0])
        else $error("reserved code drives reset");
    a_own_quiet: assert property (shadow[1] == 4'h6 && $past(shadow[1]) == 4'h6
        |-> !timer_ext_reset_out[1])
        else $error("timer selects its own output");
    a_comp_route: assert property (shadow[2] == 4'h1 && $past(shadow[2]) == 4'h1
        |-> timer_ext_reset_out[2] == $past(comparator_one_synced_in))
        else $error("comparator one not routed");
endmodule
bind timer_ext_reset_source_select timer_ext_reset_source_select_sva #(
    .TIMER_COUNT(TIMER_COUNT), .PIN_COUNT(PIN_COUNT)) u_sva (
    .core_clk_in, .resetn_in, .clk_enable_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .comparator_one_synced_in,
    .timer_ext_reset_out);
`default_nettype wire

// ### tb/timer_ext_reset_source_select_tb.sv
// Self-checking bench for the external reset selector
`timescale 1ns/100ps
`default_nettype none
module timer_ext_reset_source_select_tb;
    logic core_clk_in, resetn_in, psel, penable, pwrite, pready, pslverr, er, hit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, code;
    logic [2:0] pin_sel, ext, exp_ext;
    logic [13:0] src;
    logic [7:0] pins;
    int err_total, checks;
    reset_source_model partner (.code_in(code), .pin_sel_in(pin_sel), .hit_in(hit),
        .source_out(src), .pins_out(pins));
    timer_ext_reset_source_select DUT (.core_clk_in, .resetn_in, .clk_enable_in(1'b1),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .input_pins_in(pins), .timer_input_pin_select_in(pin_sel),
        .comparator_one_synced_in(src[0]), .comparator_two_synced_in(src[1]),
        .capture_compare_one_output_in(src[2]), .capture_compare_two_output_in(src[3]),
        .first_timer_postscaled_in(src[4]), .second_timer_postscaled_in(src[5]),
        .third_timer_postscaled_in(src[6]), .zero_cross_output_in(src[7]),
        .logic_cell_one_output_in(src[8]), .logic_cell_two_output_in(src[9]),
        .logic_cell_three_output_in(src[10]), .logic_cell_four_output_in(src[11]),
        .pwm_three_output_in(src[12]), .pwm_four_output_in(src[13]), .timer_ext_reset_out(ext));
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; pready is taken at the rising edge that ends each access cycle
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, exp,
        input logic xerr, input string what);
        int n;
        @(posedge core_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
            if (n > 16) begin
                err_total++;
                tally_and_finish();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!w) chk(what, exp, rd);
        chk("pslverr", {31'h0, xerr}, {31'h0, er});
    endtask
    // Program all three timers alike, then drive the chosen source high and low
    task automatic route(input logic [3:0] c);
        code <= c;
        for (int t = 0; t < 3; t++) acc(1'b1, 12'(t * 4), {28'h0, c}, 0, 1'b0, "w");
        acc(1'b0, 12'h00C, 0, {29'h0, c == 4'h7, c == 4'h6, c == 4'h5} | {29'h0, {3{c == 4'hF}}},
            1'b0, "reserved flags");
        for (int h = 1; h >= 0; h--) begin
            @(posedge core_clk_in);
            hit <= h[0];
            repeat (4) @(posedge core_clk_in);
            @(negedge core_clk_in);
            for (int t = 0; t < 3; t++) exp_ext[t] = h[0] && c != 4'hF && c != 4'(5 + t);
            chk("ext reset", {29'h0, exp_ext}, {29'h0, ext});
        end
        // Back on a rising edge, so the next stimulus lands there too
        @(posedge core_clk_in);
    endtask
    initial begin
        {resetn_in, psel, penable, pwrite, hit, paddr, pwdata, code, pin_sel} = '0;
        pstrb = 4'hF;
        err_total = 0;
        checks = 0;
        repeat (6) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        for (int t = 0; t < 4; t++) acc(1'b0, 12'(t * 4), 0, 0, 1'b0, "reset value");
        acc(1'b1, 12'h000, 32'hFFFF_FFF3, 0, 1'b0, "w");
        acc(1'b1, 12'h004, 32'h0000_005A, 0, 1'b0, "w");
        acc(1'b1, 12'h008, 32'h0000_000C, 0, 1'b0, "w");
        acc(1'b0, 12'h000, 0, 32'h3, 1'b0, "first field");
        acc(1'b0, 12'h004, 0, 32'hA, 1'b0, "second field");
        acc(1'b0, 12'h008, 0, 32'hC, 1'b0, "third field");
        pstrb <= 4'h0;
        acc(1'b1, 12'h000, 32'h9, 0, 1'b0, "w");
        pstrb <= 4'hF;
        acc(1'b0, 12'h000, 0, 32'h3, 1'b0, "strobe off");
        acc(1'b1, 12'h00C, 32'h1, 0, 1'b1, "status write");
        acc(1'b0, 12'h010, 0, 0, 1'b1, "unmapped");
        for (int c = 1; c < 16; c++) route(4'(c));
        for (int s = 0; s < 8; s++) begin
            pin_sel <= 3'(s);
            route(4'h0);
        end
        resetn_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        acc(1'b0, 12'h008, 0, 0, 1'b0, "field after reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire
